// ==== include/cfg_fuse_pkg.sv ====
// package: register map, fuse field layout and timing for the fuse decoder
// assumes: a 125 MHz single clock domain
package cfg_fuse_pkg;
    // byte offsets of the read-only fuse images, the control register and the status register
    localparam logic [7:0] OSC_SRC_CFG_OFS  = 8'h00;
    localparam logic [7:0] OSC_CFG_OFS      = 8'h04;
    localparam logic [7:0] WDT_CFG_OFS      = 8'h08;
    localparam logic [7:0] DBG_CFG_OFS      = 8'h0C;
    localparam logic [7:0] WDT_CTRL_OFS     = 8'h10;
    localparam logic [7:0] STATUS_OFS       = 8'h14;
    // oscillator source config fields
    localparam int NOSC_LSB      = 0;
    localparam int TWO_SPEED_BIT = 7;
    // oscillator config fields
    localparam int POSC_LSB      = 0;
    localparam int OSC_FNC_BIT   = 2;
    localparam int CKSM_LSB      = 6;
    // watchdog config fields
    localparam int WPOST_LSB     = 0;
    localparam int WPRE_BIT      = 4;
    localparam int WIN_OFF_BIT   = 6;
    localparam int WHARD_BIT     = 7;
    // debug port config fields
    localparam int CHAN_LSB      = 0;
    localparam int JTAG_BIT      = 5;
    // status register bits
    localparam int ST_RUN_BIT    = 0;
    localparam int ST_WDT_BIT    = 1;
    localparam int ST_LP_RC_BIT  = 2;
    // encodings
    localparam logic [2:0] NOSC_RC_POST  = 3'h7;
    localparam logic [2:0] NOSC_RC_DIV16 = 3'h6;
    localparam logic [2:0] NOSC_LP_RC    = 3'h5;
    localparam logic [2:0] NOSC_SOSC     = 3'h4;
    localparam logic [2:0] NOSC_PRI_PLL  = 3'h3;
    localparam logic [2:0] NOSC_PRI      = 3'h2;
    localparam logic [2:0] NOSC_RC_PLL   = 3'h1;
    localparam logic [2:0] NOSC_RC       = 3'h0;
    localparam logic [1:0] POSC_OFF      = 2'h3;
    localparam logic [1:0] POSC_HS       = 2'h2;
    localparam logic [1:0] POSC_XT       = 2'h1;
    localparam logic [1:0] POSC_EC       = 2'h0;
    localparam logic [1:0] CHAN_PAIR1    = 2'h3;
    localparam logic [1:0] CHAN_PAIR2    = 2'h2;
    localparam logic [1:0] CHAN_PAIR3    = 2'h1;
    localparam logic [15:0] PRE_DIV_LONG = 16'h0080;
    localparam logic [15:0] PRE_DIV_SHORT= 16'h0020;
    // timing
    localparam int CLK_MHZ         = 125;
    localparam int STARTUP_US      = 20;
    localparam int STARTUP_CYCLES  = STARTUP_US * CLK_MHZ;
    localparam int LP_RC_KHZ       = 32;
    localparam int WDT_TICK_CYCLES = (CLK_MHZ * 1000) / LP_RC_KHZ;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ==== rtl/cfg_fuse_decoder.sv ====
// fuse decoder: latches configuration fuses at reset, decodes them into
// clock, watchdog and debug settings, holds off execution at start-up
// assumes: fuse image stable while aresetn low; single 125 MHz clock
//
// Contract
// - two-speed: start on fast RC, then switch
// - decode 3-bit initial oscillator selection
// - decode clock switching and fail-safe monitor
// - second osc pin: clock out or GPIO
// - decode primary oscillator mode
// - hard enable: watchdog always runs, RC on
// - otherwise software bit enables watchdog
// - window-disable 1 non-window, 0 window
// - prescaler 128 when 1, 32 when 0
// - postscaler power-of-two, 1111 gives 32768
// - boundary scan enabled by its field
// - debug channel selects pin pair
// - hold execution about 20 us after power-on
// - same hold-off after every power-down
// - watchdog clocked from 32 kHz low-power RC
// - software watchdog enable cleared on reset
module cfg_fuse_decoder #(
    parameter int STARTUP_CYCLES = cfg_fuse_pkg::STARTUP_CYCLES
) (
    input  wire logic        aclk,              // system clock
    input  wire logic        aresetn,           // sync reset, active low
    input  wire logic        power_down,        // core supply removed
    input  wire logic [7:0]  fuse_osc_src,      // source config image
    input  wire logic [7:0]  fuse_osc,          // oscillator config image
    input  wire logic [7:0]  fuse_wdt,          // watchdog config image
    input  wire logic [7:0]  fuse_dbg,          // debug config image
    input  wire logic        selected_osc_ready,// chosen osc stable
    input  wire logic [31:0] s_axi_awaddr,      // write address
    input  wire logic        s_axi_awvalid,     // write address valid
    output logic             s_axi_awready,     // write address ready
    input  wire logic [31:0] s_axi_wdata,       // write data
    input  wire logic [3:0]  s_axi_wstrb,       // write strobes
    input  wire logic        s_axi_wvalid,      // write data valid
    output logic             s_axi_wready,      // write data ready
    output logic [1:0]       s_axi_bresp,       // write response
    output logic             s_axi_bvalid,      // write response valid
    input  wire logic        s_axi_bready,      // write response ready
    input  wire logic [31:0] s_axi_araddr,      // read address
    input  wire logic        s_axi_arvalid,     // read address valid
    output logic             s_axi_arready,     // read address ready
    output logic [31:0]      s_axi_rdata,       // read data
    output logic [1:0]       s_axi_rresp,       // read response
    output logic             s_axi_rvalid,      // read data valid
    input  wire logic        s_axi_rready,      // read data ready
    output logic             exec_enable,       // code may execute
    output logic             run_on_fast_rc,    // core on fast RC now
    output logic [2:0]       initial_osc_select,// target oscillator
    output logic             use_pll,           // PLL in path
    output logic             fast_rc_div16,     // fast RC divided by 16
    output logic             fast_rc_postscale, // fast RC postscaler used
    output logic             clock_switch_en,   // switching allowed
    output logic             fail_safe_en,      // fail-safe monitor on
    output logic [1:0]       primary_osc_mode,  // primary osc mode
    output logic             osc_pin_clkout,    // pin drives clock out
    output logic             osc_pin_gpio,      // pin is digital I/O
    output logic             watchdog_run,      // watchdog running
    output logic             lp_rc_enable,      // low-power RC on
    output logic             watchdog_window,   // window mode
    output logic [15:0]      wdt_prescale_div,  // prescaler ratio
    output logic [15:0]      wdt_postscale_div, // postscaler ratio
    output logic             wdt_tick,          // 32 kHz watchdog enable
    output logic             boundary_scan_en,  // boundary scan port on
    output logic [2:0]       debug_pair_onehot, // pair 3..1 one-hot
    output logic             debug_reserved     // reserved channel code
);
    localparam int TW = $clog2(STARTUP_CYCLES + 1);
    localparam int PW = $clog2(cfg_fuse_pkg::WDT_TICK_CYCLES + 1);

    typedef enum logic [1:0] {ST_HOLD, ST_FAST_RC, ST_RUN} boot_t;

    // ****************************************************************
    // fuse capture
    // ****************************************************************
    logic [7:0] src_r, osc_r, wdt_r, dbg_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_r <= fuse_osc_src;
            osc_r <= fuse_osc;
            wdt_r <= fuse_wdt;
            dbg_r <= fuse_dbg;
        end
    end

    // ****************************************************************
    // decode
    // ****************************************************************
    logic [2:0] nosc;
    logic [1:0] cksm;
    logic       hard_en, crystal;
    assign nosc = src_r[cfg_fuse_pkg::NOSC_LSB +: 3];
    assign cksm = osc_r[cfg_fuse_pkg::CKSM_LSB +: 2];
    assign hard_en = wdt_r[cfg_fuse_pkg::WHARD_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            initial_osc_select <= 3'h0;
            use_pll            <= 1'b0;
            fast_rc_div16      <= 1'b0;
            fast_rc_postscale  <= 1'b0;
            clock_switch_en    <= 1'b0;
            fail_safe_en       <= 1'b0;
            primary_osc_mode   <= 2'h0;
            osc_pin_clkout     <= 1'b0;
            osc_pin_gpio       <= 1'b0;
            watchdog_window    <= 1'b0;
            wdt_prescale_div   <= 16'h0000;
            wdt_postscale_div  <= 16'h0000;
            boundary_scan_en   <= 1'b0;
            debug_pair_onehot  <= 3'h0;
            debug_reserved     <= 1'b0;
        end else begin
            initial_osc_select <= nosc;
            use_pll <= (nosc == cfg_fuse_pkg::NOSC_PRI_PLL)
                    || (nosc == cfg_fuse_pkg::NOSC_RC_PLL);
            fast_rc_div16 <= (nosc == cfg_fuse_pkg::NOSC_RC_DIV16);
            fast_rc_postscale <= (nosc == cfg_fuse_pkg::NOSC_RC_POST);
            clock_switch_en <= !cksm[1];
            fail_safe_en    <= (cksm == 2'h0);
            primary_osc_mode <= osc_r[cfg_fuse_pkg::POSC_LSB +: 2];
            osc_pin_clkout <= !crystal
                && osc_r[cfg_fuse_pkg::OSC_FNC_BIT];
            osc_pin_gpio   <= !crystal
                && !osc_r[cfg_fuse_pkg::OSC_FNC_BIT];
            watchdog_window <= !wdt_r[cfg_fuse_pkg::WIN_OFF_BIT];
            wdt_prescale_div <= wdt_r[cfg_fuse_pkg::WPRE_BIT]
                ? cfg_fuse_pkg::PRE_DIV_LONG
                : cfg_fuse_pkg::PRE_DIV_SHORT;
            wdt_postscale_div <= 16'h0001
                << wdt_r[cfg_fuse_pkg::WPOST_LSB +: 4];
            boundary_scan_en <= dbg_r[cfg_fuse_pkg::JTAG_BIT];
            debug_pair_onehot <=
                chan_decode(dbg_r[cfg_fuse_pkg::CHAN_LSB +: 2]);
            debug_reserved <=
                (dbg_r[cfg_fuse_pkg::CHAN_LSB +: 2] == 2'h0);
        end
    end

    assign crystal = (osc_r[cfg_fuse_pkg::POSC_LSB +: 2]
                      == cfg_fuse_pkg::POSC_HS)
                  || (osc_r[cfg_fuse_pkg::POSC_LSB +: 2]
                      == cfg_fuse_pkg::POSC_XT);

    function automatic logic [2:0] chan_decode(input logic [1:0] c);
        logic [2:0] v;
        v = 3'h0;
        if (c == cfg_fuse_pkg::CHAN_PAIR1) v = 3'h1;
        else if (c == cfg_fuse_pkg::CHAN_PAIR2) v = 3'h2;
        else if (c == cfg_fuse_pkg::CHAN_PAIR3) v = 3'h4;
        return v;
    endfunction

    // ****************************************************************
    // start-up hold-off and two-speed start
    // ****************************************************************
    boot_t          boot_r;
    logic [TW-1:0]  hold_r;

    always_ff @(posedge aclk) begin
        if (!aresetn || power_down) begin
            boot_r <= ST_HOLD;
            hold_r <= TW'(STARTUP_CYCLES);
        end else begin
            case (boot_r)
                ST_HOLD: begin
                    if (hold_r > TW'(1)) begin
                        hold_r <= hold_r - TW'(1);
                    end else if (src_r[cfg_fuse_pkg::TWO_SPEED_BIT]) begin
                        boot_r <= ST_FAST_RC;
                    end else begin
                        boot_r <= ST_RUN;
                    end
                end
                ST_FAST_RC: begin
                    if (selected_osc_ready) begin
                        boot_r <= ST_RUN;
                    end
                end
                default: boot_r <= boot_r;
            endcase
        end
    end

    assign exec_enable    = (boot_r != ST_HOLD);
    assign run_on_fast_rc = (boot_r == ST_FAST_RC);

    // ****************************************************************
    // watchdog enable and 32 kHz tick
    // ****************************************************************
    logic           soft_en_r;
    logic [PW-1:0]  tick_cnt_r;

    assign watchdog_run = hard_en || soft_en_r;
    assign lp_rc_enable = watchdog_run;

    always_ff @(posedge aclk) begin
        if (!aresetn || !watchdog_run) begin
            tick_cnt_r <= '0;
            wdt_tick   <= 1'b0;
        end else if (tick_cnt_r == PW'(cfg_fuse_pkg::WDT_TICK_CYCLES-1)) begin
            tick_cnt_r <= '0;
            wdt_tick   <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + PW'(1);
            wdt_tick   <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic aw_hold_r, w_hold_r;
    logic [7:0]  aw_r;
    logic [31:0] wd_r;
    logic        wstb_r;
    logic        do_write;

    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_r      <= 8'h00;
            wd_r      <= 32'h0000_0000;
            wstb_r    <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cfg_fuse_pkg::AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_r      <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wd_r     <= s_axi_wdata;
                wstb_r   <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= reg_known(aw_r) ? cfg_fuse_pkg::AXI_OKAY
                                                : cfg_fuse_pkg::AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_en_r <= 1'b0;
        end else if (do_write && wstb_r
                     && aw_r == cfg_fuse_pkg::WDT_CTRL_OFS) begin
            soft_en_r <= wd_r[0];
        end
    end

    function automatic logic reg_known(input logic [7:0] a);
        return a == cfg_fuse_pkg::OSC_SRC_CFG_OFS
            || a == cfg_fuse_pkg::OSC_CFG_OFS
            || a == cfg_fuse_pkg::WDT_CFG_OFS
            || a == cfg_fuse_pkg::DBG_CFG_OFS
            || a == cfg_fuse_pkg::WDT_CTRL_OFS
            || a == cfg_fuse_pkg::STATUS_OFS;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= cfg_fuse_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= cfg_fuse_pkg::AXI_OKAY;
            if (s_axi_araddr[7:0] == cfg_fuse_pkg::OSC_SRC_CFG_OFS) begin
                s_axi_rdata <= {24'h000000, src_r};
            end else if (s_axi_araddr[7:0] == cfg_fuse_pkg::OSC_CFG_OFS) begin
                s_axi_rdata <= {24'h000000, osc_r};
            end else if (s_axi_araddr[7:0] == cfg_fuse_pkg::WDT_CFG_OFS) begin
                s_axi_rdata <= {24'h000000, wdt_r};
            end else if (s_axi_araddr[7:0] == cfg_fuse_pkg::DBG_CFG_OFS) begin
                s_axi_rdata <= {24'h000000, dbg_r};
            end else if (s_axi_araddr[7:0] == cfg_fuse_pkg::WDT_CTRL_OFS) begin
                s_axi_rdata <= {31'h00000000, soft_en_r};
            end else if (s_axi_araddr[7:0] == cfg_fuse_pkg::STATUS_OFS) begin
                s_axi_rdata <= {29'h00000000, lp_rc_enable, watchdog_run,
                                exec_enable};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= cfg_fuse_pkg::AXI_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_held_off;
        !exec_enable [*8];
    endsequence

    a_hold_after_reset: assert property (@(posedge aclk)
        $rose(aresetn) |-> s_held_off)
        else $error("execution enabled too soon after reset");
    a_hold_after_pdown: assert property (@(posedge aclk)
        power_down |=> !exec_enable)
        else $error("execution not held after power-down");
    a_two_speed_start: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($rose(exec_enable) && src_r[cfg_fuse_pkg::TWO_SPEED_BIT])
        |-> run_on_fast_rc)
        else $error("two-speed start not on fast RC");
    a_hard_wdt_runs: assert property (@(posedge aclk)
        disable iff (!aresetn) hard_en |-> watchdog_run && lp_rc_enable)
        else $error("hard-enabled watchdog stopped");
    a_soft_wdt_off: assert property (@(posedge aclk)
        disable iff (!aresetn) (!hard_en && !soft_en_r) |-> !watchdog_run)
        else $error("watchdog runs with both enables clear");
    a_soft_clr_reset: assert property (@(posedge aclk)
        !aresetn |=> !soft_en_r)
        else $error("software enable survived reset");
    a_fsm_decode: assert property (@(posedge aclk)
        disable iff (!aresetn) $past(aresetn) |->
        (fail_safe_en == (cksm == 2'h0)) && (clock_switch_en == !cksm[1]))
        else $error("clock switch mode decode wrong");
    a_prescale_ratio: assert property (@(posedge aclk)
        disable iff (!aresetn) $past(aresetn) |-> wdt_prescale_div ==
        (wdt_r[cfg_fuse_pkg::WPRE_BIT] ? 16'h0080 : 16'h0020))
        else $error("prescaler ratio wrong");
    a_pin_exclusive: assert property (@(posedge aclk)
        disable iff (!aresetn) !(osc_pin_clkout && osc_pin_gpio))
        else $error("second osc pin has two functions");
    a_fuses_static: assert property (@(posedge aclk)
        disable iff (!aresetn) $past(aresetn) |-> $stable(wdt_r))
        else $error("fuse image changed while running");
endmodule

// ==== bench/osc_ready_model.sv ====
// partner: clock unit answering the decoder's fast RC start-up phase
// assumes: one clock, synchronous active-low reset
module osc_ready_model (
    input  wire logic       aclk,       // system clock
    input  wire logic       aresetn,    // sync reset, active low
    input  wire logic       on_fast_rc, // core runs on fast RC
    input  wire logic [7:0] delay,      // cycles until ready
    output logic            osc_ready   // chosen oscillator stable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    // ready comes a set time after the fast RC phase starts
    always_ff @(posedge aclk) begin
        if (!aresetn)
            cnt_r <= 8'h00;
        else if (on_fast_rc && cnt_r < delay)
            cnt_r <= cnt_r + 8'h01;
    end
    assign osc_ready = aresetn && cnt_r >= delay;
endmodule

// ==== bench/tb_config_fuse_decoder.sv ====
// testbench: random fuse images, decode, hold-off, bus and watchdog checks
// assumes: package, design and partner model compiled first
module tb_config_fuse_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // signals
    // ********************
    localparam int SC = 10;
    logic        aclk = 1'h0, aresetn = 1'h0, power_down = 1'h0;
    logic [7:0]  fs = 8'h0, fo = 8'h0, fw = 8'h0, fd = 8'h0, dly = 8'h1;
    logic [7:0]  es, eo, ew, ed;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, primary_osc_mode;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, selected_osc_ready;
    logic        exec_enable, run_on_fast_rc, use_pll, fast_rc_div16;
    logic        fast_rc_postscale, clock_switch_en, fail_safe_en;
    logic        osc_pin_clkout, osc_pin_gpio, watchdog_run, lp_rc_enable;
    logic        watchdog_window, wdt_tick, boundary_scan_en;
    logic        debug_reserved;
    logic [2:0]  initial_osc_select, debug_pair_onehot;
    logic [15:0] wdt_prescale_div, wdt_postscale_div;
    int          errors = 0, checks_done = 0;
    cfg_fuse_decoder #(.STARTUP_CYCLES(SC)) dut_u (
        .aclk, .aresetn, .power_down, .fuse_osc_src(fs), .fuse_osc(fo),
        .fuse_wdt(fw), .fuse_dbg(fd), .selected_osc_ready, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .exec_enable, .run_on_fast_rc, .initial_osc_select, .use_pll,
        .fast_rc_div16, .fast_rc_postscale, .clock_switch_en, .fail_safe_en,
        .primary_osc_mode, .osc_pin_clkout, .osc_pin_gpio, .watchdog_run,
        .lp_rc_enable, .watchdog_window, .wdt_prescale_div,
        .wdt_postscale_div, .wdt_tick, .boundary_scan_en,
        .debug_pair_onehot, .debug_reserved);
    osc_ready_model partner_u (.aclk, .aresetn, .on_fast_rc(run_on_fast_rc),
        .delay(dly), .osc_ready(selected_osc_ready));
    initial forever #4 aclk = ~aclk;
    // ********************
    // tasks
    // ********************
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rd_reg(input logic [31:0] a);
        logic a_ok, done;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        done = 1'h0;
        while (!done) begin
            @(negedge aclk);
            a_ok = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (a_ok) s_axi_arvalid <= 1'h0;
            if (done) s_axi_rready <= 1'h0;
        end
        chk(done, 1'h1);
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        logic a_ok, w_ok, done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        done = 1'h0;
        while (!done) begin
            @(negedge aclk);
            a_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (a_ok) s_axi_awvalid <= 1'h0;
            if (w_ok) s_axi_wvalid <= 1'h0;
            if (done) s_axi_bready <= 1'h0;
        end
        chk({done, rsp}, {1'h1, a[7:0] > cfg_fuse_pkg::STATUS_OFS
            ? cfg_fuse_pkg::AXI_SLVERR : cfg_fuse_pkg::AXI_OKAY});
    endtask
    // counts cycles with execution held off after a release
    task automatic hold_chk(input bit two);
        int n;
        bit saw;
        n = 0;
        saw = 0;
        for (int k = 0; k < 80; k++) begin
            @(negedge aclk);
            if (exec_enable !== 1'h1) n++;
            saw |= (run_on_fast_rc === 1'h1);
        end
        chk(n >= SC - 1 && n <= SC + 2, 1'h1);
        if (two) chk({saw, run_on_fast_rc}, {fs[7], 1'h0});
    endtask
    task automatic do_reset(input logic [3:0] i);
        logic [31:0] r;
        r = $urandom;
        @(posedge aclk);
        aresetn <= 1'h0;
        fs <= {r[7:3], i[2:0]};
        fo <= {i[3:2], r[13:10], i[1:0]};
        fw <= {r[23:20], i[3:0]};
        fd <= {r[31:26], i[1:0]};
        dly <= {3'h0, r[9:5]} + 8'h1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        hold_chk(1);
    endtask
    task automatic dec_chk();
        logic [2:0] oh;
        logic pin;
        pin = !(eo[1:0] == 2'h2 || eo[1:0] == 2'h1);
        oh = ed[1:0] == 2'h3 ? 3'h1 : ed[1:0] == 2'h2 ? 3'h2
           : ed[1:0] == 2'h1 ? 3'h4 : 3'h0;
        chk({initial_osc_select, use_pll, fast_rc_div16, fast_rc_postscale},
            {es[2:0], es[2:0] == 3'h3 || es[2:0] == 3'h1,
             es[2:0] == 3'h6, es[2:0] == 3'h7});
        chk({clock_switch_en, fail_safe_en}, {!eo[7], eo[7:6] == 2'h0});
        chk(primary_osc_mode, eo[1:0]);
        chk({osc_pin_clkout, osc_pin_gpio}, {pin & eo[2], pin & !eo[2]});
        chk(watchdog_window, !ew[6]);
        chk(boundary_scan_en, ed[5]);
        chk({debug_pair_onehot, debug_reserved}, {oh, ed[1:0] == 2'h0});
        chk(wdt_prescale_div, ew[4] ? 16'h80 : 16'h20);
        chk(wdt_postscale_div, 17'h1 << ew[3:0]);
    endtask
    task automatic tick_chk();
        int n, t;
        n = 0;
        t = 0;
        for (int k = 0; k < 9000 && t < 2; k++) begin
            @(negedge aclk);
            if (t == 1) n++;
            if (wdt_tick === 1'h1) t++;
        end
        chk(n, cfg_fuse_pkg::WDT_TICK_CYCLES);
    endtask
    task automatic bus_chk(input bit tick);
        logic [7:0] img [4];
        logic h;
        img = '{es, eo, ew, ed};
        h = ew[7];
        wr_reg(32'h0, 32'hFF);
        for (int k = 0; k < 4; k++) begin
            rd_reg(32'(4 * k));
            chk({rsp, rd}, {cfg_fuse_pkg::AXI_OKAY, 24'h0, img[k]});
        end
        rd_reg(32'h18);
        chk({rsp, rd}, {cfg_fuse_pkg::AXI_SLVERR, 32'h0});
        wr_reg(32'h18, 32'h1);
        // strobe of byte 0 low: the enable write must be ignored
        s_axi_wstrb <= 4'hE;
        wr_reg(32'(cfg_fuse_pkg::WDT_CTRL_OFS), 32'h1);
        s_axi_wstrb <= 4'hF;
        rd_reg(32'(cfg_fuse_pkg::WDT_CTRL_OFS));
        chk(rd, 32'h0);
        chk({watchdog_run, lp_rc_enable}, {h, h});
        wr_reg(32'(cfg_fuse_pkg::WDT_CTRL_OFS), 32'h1);
        @(negedge aclk);
        chk({watchdog_run, lp_rc_enable}, 2'h3);
        rd_reg(32'(cfg_fuse_pkg::STATUS_OFS));
        chk(rd, 32'h7);
        if (tick) tick_chk();
        wr_reg(32'(cfg_fuse_pkg::WDT_CTRL_OFS), 32'h0);
        @(negedge aclk);
        chk({watchdog_run, lp_rc_enable}, {h, h});
    endtask
    // ********************
    // sequence
    // ********************
    initial begin
        void'($urandom(32'h9371));
        for (int i = 0; i < 16; i++) begin
            do_reset(4'(i));
            {es, eo, ew, ed} = {fs, fo, fw, fd};
            dec_chk();
            @(posedge aclk);
            {fs, fo, fw, fd} <= ~{fs, fo, fw, fd};
            bus_chk(i == 15);
            dec_chk();
            // leave the soft enable set so the next reset must clear it
            wr_reg(32'(cfg_fuse_pkg::WDT_CTRL_OFS), 32'h1);
        end
        @(posedge aclk);
        power_down <= 1'h1;
        repeat (5) @(posedge aclk);
        @(negedge aclk);
        chk(exec_enable, 1'h0);
        @(posedge aclk);
        power_down <= 1'h0;
        hold_chk(0);
        end_sim();
    end
    initial begin
        #(8 * 60000);
        errors++;
        end_sim();
    end
endmodule
